// File: rtl/utc_pkg.sv
// shared constants and types of the uart transmit channel
package utc_pkg;
	// ****************************************
	// bus and register map
	// ****************************************
	localparam int ADDR_W = 5;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
	localparam logic [ADDR_W-1:0] OFS_TRIG = 5'h04;
	localparam logic [ADDR_W-1:0] OFS_DATA = 5'h08;
	localparam logic [ADDR_W-1:0] OFS_STAT = 5'h0C;
	localparam logic [ADDR_W-1:0] OFS_PRES = 5'h10;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ****************************************
	// field positions
	// ****************************************
	localparam int TRIG_START = 0;
	localparam int TRIG_STOP = 1;
	localparam int STAT_SE = 0;
	localparam int STAT_TSF = 1;
	localparam int STAT_BFF = 2;
	localparam int DATA_TX_LSB = 0;
	localparam int DATA_BAUD_LSB = 8;
	localparam int CTRL_W = 10;

	// ****************************************
	// types
	// ****************************************
	// control word, bit 0 is the serial output level
	typedef struct packed {
		logic [1:0] parity;
		logic stop2;
		logic lsb_first;
		logic len8;
		logic clk_gate;
		logic int_sel;
		logic level_inv;
		logic out_en;
		logic out_level;
	} utc_ctrl_type;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_START = 5'h02,
		ST_DATA = 5'h04,
		ST_PAR = 5'h08,
		ST_STOP = 5'h10
	} utc_state_type;

	// ****************************************
	// reset values and last data bit indexes
	// ****************************************
	localparam utc_ctrl_type CTRL_RST = 10'h061;
	localparam logic [7:0] BAUD_RST = 8'h04;
	localparam logic [3:0] PRES_RST = 4'h0;
	localparam logic [2:0] LAST_BIT8 = 3'h7;
	localparam logic [2:0] LAST_BIT7 = 3'h6;
endpackage : utc_pkg

// File: rtl/utc_bit_timer.sv
// bit period timer: prescaler plus baud divider
`timescale 1ns/100ps
`default_nettype none
module utc_bit_timer import utc_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// setup
	input wire logic run,
	input wire logic [3:0] presc,
	input wire logic [6:0] div,
	// one pulse per bit
	output logic tick
);
	logic [15:0] pre_q;
	logic [7:0] cnt_q;
	logic tick_q;

	// operation clock enable is fclk divided by two to the presc
	wire [15:0] pre_mask = 16'(16'h0001 << presc) - 16'h0001;
	wire mck = (pre_q & pre_mask) == pre_mask;
	// bit period is (div + 1) * 2 operation clocks
	wire [7:0] last = {div, 1'b1};
	wire hit = run & mck & (cnt_q == last);

	// free prescaler keeps running so its phase is no hazard
	always_ff @(posedge clk) begin
		if (rst) begin
			pre_q <= 16'h0000;
			cnt_q <= 8'h00;
			tick_q <= 1'b0;
		end else begin
			pre_q <= pre_q + 16'h0001;
			tick_q <= hit;
			if (!run || hit)
				cnt_q <= 8'h00;
			else if (mck)
				cnt_q <= cnt_q + 8'h01;
		end
	end

	assign tick = tick_q;
endmodule : utc_bit_timer
`default_nettype wire

// File: rtl/utc_uart_tx.sv
// uart transmit channel with axi4-lite register port
`timescale 1ns/100ps
`default_nettype none
module utc_uart_tx import utc_pkg::*; (
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic SRST,
	// axi4-lite write address
	input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	// axi4-lite write data
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	// axi4-lite write response
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	// axi4-lite read address
	input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	// axi4-lite read data
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	// serial line
	output logic TXD,
	output logic TXD_OE,
	// transmit interrupt pulse
	output logic TX_IRQ
);
	// ****************************************
	// helpers
	// ****************************************
	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		return (a == OFS_CTRL) || (a == OFS_TRIG) || (a == OFS_DATA) ||
			(a == OFS_STAT) || (a == OFS_PRES);
	endfunction : is_mapped

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		end
		return r;
	endfunction : merge

	function automatic logic [7:0] rev8(input logic [7:0] v);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < 8; i++) begin
			r[i] = v[7-i];
		end
		return r;
	endfunction : rev8

	// ****************************************
	// bus slave state
	// ****************************************
	logic aw_rdy_q;
	logic w_rdy_q;
	logic b_vld_q;
	logic ar_rdy_q;
	logic r_vld_q;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic [1:0] b_resp_q;
	logic [1:0] r_resp_q;
	logic [31:0] r_data_q;

	// ****************************************
	// channel state
	// ****************************************
	utc_ctrl_type ctrl_q;
	utc_ctrl_type ctrl_d;
	utc_state_type state_q;
	utc_state_type state_d;
	logic en_q;
	logic bff_q;
	logic [7:0] buf_q;
	logic [7:0] baud_q;
	logic [3:0] pres_q;
	logic [7:0] sh_q;
	logic [7:0] sh_d;
	logic [2:0] cnt_q;
	logic [2:0] cnt_d;
	logic par_q;
	logic stop2_q;
	logic stop2_d;
	logic irq_q;
	logic load;
	logic fin;
	logic tick;
	logic line_bit;

	// ****************************************
	// write decode
	// ****************************************
	// both halves captured and no response pending: perform the write
	wire wr_fire = ~aw_rdy_q & ~w_rdy_q & ~b_vld_q;
	wire rd_fire = S_AXI_ARVALID & ar_rdy_q;
	wire wr_ctrl = wr_fire & (aw_addr_q == OFS_CTRL);
	wire wr_trig = wr_fire & (aw_addr_q == OFS_TRIG) & w_strb_q[0];
	wire wr_data = wr_fire & (aw_addr_q == OFS_DATA);
	wire wr_pres = wr_fire & (aw_addr_q == OFS_PRES) & w_strb_q[0];
	wire wr_tx = wr_data & w_strb_q[0];
	wire wr_baud = wr_data & w_strb_q[1];
	wire start_req = wr_trig & w_data_q[TRIG_START];
	wire stop_req = wr_trig & w_data_q[TRIG_STOP];
	wire [31:0] ctrl_wr = merge({22'h000000, ctrl_q}, w_data_q, w_strb_q);

	// clock gate low holds the rest of the unit in reset
	wire unit_rst = SRST | ~ctrl_q.clk_gate;
	wire busy = state_q != ST_IDLE;

	// ****************************************
	// frame preparation
	// ****************************************
	// msb first is sent by reversing the used bits and shifting from bit 0
	wire [7:0] data_used = ctrl_q.len8 ? buf_q : {1'b0, buf_q[6:0]};
	wire [7:0] data_rev = ctrl_q.len8 ? rev8(buf_q) : rev8({buf_q[6:0], 1'b0});
	wire [7:0] frame_bits = ctrl_q.lsb_first ? data_used : data_rev;
	wire par_bit = (ctrl_q.parity == 2'h2) ? ^data_used :
		(ctrl_q.parity == 2'h3) ? ~^data_used : 1'b0;
	wire [2:0] last_bit = ctrl_q.len8 ? LAST_BIT8 : LAST_BIT7;

	// ****************************************
	// frame sequencer
	// ****************************************
	always_comb begin
		state_d = state_q;
		sh_d = sh_q;
		cnt_d = cnt_q;
		stop2_d = stop2_q;
		load = 1'b0;
		fin = 1'b0;
		unique case (state_q)
			ST_IDLE: begin
				if (en_q && bff_q) begin
					state_d = ST_START;
					sh_d = frame_bits;
					cnt_d = last_bit;
					load = 1'b1;
				end
			end
			ST_START: begin
				if (tick)
					state_d = ST_DATA;
			end
			ST_DATA: begin
				if (tick) begin
					sh_d = sh_q >> 1;
					cnt_d = cnt_q - 3'h1;
					stop2_d = 1'b0;
					if (cnt_q == 3'h0)
						state_d = (ctrl_q.parity != 2'h0) ? ST_PAR : ST_STOP;
				end
			end
			ST_PAR: begin
				if (tick)
					state_d = ST_STOP;
			end
			ST_STOP: begin
				if (tick) begin
					if (ctrl_q.stop2 && !stop2_q) begin
						stop2_d = 1'b1;
					end else begin
						state_d = ST_IDLE;
						fin = 1'b1;
					end
				end
			end
		endcase
		// a stop abandons any frame at once; a pending byte stays buffered, not lost
		if (stop_req) begin
			state_d = ST_IDLE;
			load = 1'b0;
		end
	end

	// level of the line for the coming bit; idle and stop are mark
	assign line_bit = (state_d == ST_START) ? 1'b0 :
		(state_d == ST_DATA) ? sh_d[0] :
		(state_d == ST_PAR) ? par_q : 1'b1;
	wire hw_drive = (state_d != ST_IDLE) | fin;

	// ****************************************
	// control word update
	// ****************************************
	// hardware owns the level bit while a frame runs; otherwise software may force it
	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_ctrl)
			ctrl_d = utc_ctrl_type'(ctrl_wr[CTRL_W-1:0]);
		else if (!ctrl_q.clk_gate)
			ctrl_d = CTRL_RST;
		if (hw_drive && ctrl_q.clk_gate)
			ctrl_d.out_level = line_bit ^ ctrl_q.level_inv;
	end

	always_ff @(posedge SYS_CLK) begin
		if (SRST)
			ctrl_q <= CTRL_RST;
		else
			ctrl_q <= ctrl_d;
	end

	// ****************************************
	// channel registers
	// ****************************************
	// a buffer write in the load cycle wins over the clear
	always_ff @(posedge SYS_CLK) begin
		if (unit_rst) begin
			state_q <= ST_IDLE;
			en_q <= 1'b0;
			bff_q <= 1'b0;
			buf_q <= 8'h00;
			baud_q <= BAUD_RST;
			pres_q <= PRES_RST;
			sh_q <= 8'h00;
			cnt_q <= 3'h0;
			par_q <= 1'b0;
			stop2_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			state_q <= state_d;
			sh_q <= sh_d;
			cnt_q <= cnt_d;
			stop2_q <= stop2_d;
			if (stop_req)
				en_q <= 1'b0;
			else if (start_req)
				en_q <= 1'b1;
			if (wr_tx) begin
				buf_q <= w_data_q[DATA_TX_LSB +: 8];
				bff_q <= 1'b1;
			end else if (load) begin
				bff_q <= 1'b0;
			end
			if (load)
				par_q <= par_bit;
			if (wr_baud)
				baud_q <= w_data_q[DATA_BAUD_LSB +: 8];
			if (wr_pres)
				pres_q <= w_data_q[3:0];
			// buffer empty on load, transfer end on the last stop bit
			irq_q <= (load & ctrl_q.int_sel) | (fin & ~ctrl_q.int_sel);
		end
	end

	// ****************************************
	// bit timing
	// ****************************************
	utc_bit_timer u_timer (
		.clk(SYS_CLK),
		.rst(unit_rst),
		.run(busy),
		.presc(pres_q),
		.div(baud_q[7:1]),
		.tick(tick)
	);

	// ****************************************
	// read decode
	// ****************************************
	wire [31:0] stat_val = {29'h00000000, bff_q, busy, en_q};
	wire [31:0] rd_val = (S_AXI_ARADDR == OFS_CTRL) ? {22'h000000, ctrl_q} :
		(S_AXI_ARADDR == OFS_DATA) ? {16'h0000, baud_q, buf_q} :
		(S_AXI_ARADDR == OFS_STAT) ? stat_val :
		(S_AXI_ARADDR == OFS_PRES) ? {28'h0000000, pres_q} : 32'h00000000;

	// ****************************************
	// axi4-lite handshakes
	// ****************************************
	// address and data are caught separately so either may come first
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			aw_rdy_q <= 1'b1;
			w_rdy_q <= 1'b1;
			b_vld_q <= 1'b0;
			b_resp_q <= RESP_OKAY;
			aw_addr_q <= '0;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
		end else begin
			if (S_AXI_AWVALID && aw_rdy_q) begin
				aw_rdy_q <= 1'b0;
				aw_addr_q <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && w_rdy_q) begin
				w_rdy_q <= 1'b0;
				w_data_q <= S_AXI_WDATA;
				w_strb_q <= S_AXI_WSTRB;
			end
			if (wr_fire) begin
				b_vld_q <= 1'b1;
				b_resp_q <= is_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
			end
			if (b_vld_q && S_AXI_BREADY) begin
				b_vld_q <= 1'b0;
				aw_rdy_q <= 1'b1;
				w_rdy_q <= 1'b1;
			end
		end
	end

	// one read in flight; data held until rready
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			ar_rdy_q <= 1'b1;
			r_vld_q <= 1'b0;
			r_data_q <= 32'h00000000;
			r_resp_q <= RESP_OKAY;
		end else if (rd_fire) begin
			ar_rdy_q <= 1'b0;
			r_vld_q <= 1'b1;
			r_data_q <= rd_val;
			r_resp_q <= is_mapped(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
		end else if (r_vld_q && S_AXI_RREADY) begin
			ar_rdy_q <= 1'b1;
			r_vld_q <= 1'b0;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign S_AXI_AWREADY = aw_rdy_q;
	assign S_AXI_WREADY = w_rdy_q;
	assign S_AXI_BVALID = b_vld_q;
	assign S_AXI_BRESP = b_resp_q;
	assign S_AXI_ARREADY = ar_rdy_q;
	assign S_AXI_RVALID = r_vld_q;
	assign S_AXI_RDATA = r_data_q;
	assign S_AXI_RRESP = r_resp_q;
	assign TXD = ctrl_q.out_level;
	assign TXD_OE = ctrl_q.out_en;
	assign TX_IRQ = irq_q;
endmodule : utc_uart_tx
`default_nettype wire

// File: sim/utc_rx_model.sv
// behavioural far-end receiver for the transmit line
`timescale 1ns/100ps
`default_nettype none
module utc_rx_model #(
	parameter int BIT_CLKS = 6
) (
	// link
	input wire logic clk,
	input wire logic line,
	// received frame
	output logic [7:0] rx_byte,
	output logic rx_done
);
	// ****
	// frame capture
	// ****
	// mid-bit sampling, lsb first; frames with a low stop bit are dropped
	initial begin
		rx_done = 1'b0;
		rx_byte = 8'h00;
		forever begin
			@(posedge clk iff line === 1'b1);
			@(posedge clk iff line === 1'b0);
			repeat (BIT_CLKS / 2) @(posedge clk);
			if (line === 1'b0) begin
				for (int i = 0; i < 8; i++) begin
					repeat (BIT_CLKS) @(posedge clk);
					rx_byte[i] = line;
				end
				repeat (BIT_CLKS) @(posedge clk);
				if (line === 1'b1) begin
					rx_done <= 1'b1;
					@(posedge clk);
					rx_done <= 1'b0;
				end
			end
		end
	end
endmodule : utc_rx_model
`default_nettype wire

// File: sim/utc_uart_tx_properties.sv
// bus handshake and line timing checks of the transmit channel
`timescale 1ns/100ps
`default_nettype none
module utc_uart_tx_chk import utc_pkg::*; (
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic SRST,
	// bus handshakes
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	// serial line
	input wire logic TXD,
	input wire logic TXD_OE,
	input wire logic TX_IRQ
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (SRST);
	// ****
	// properties
	// ****
	reset_idle_a: assert property ($fell(SRST) |-> TXD && !TXD_OE && !TX_IRQ)
		else $error("line not idle after reset");
	bit_hold_a: assert property ($changed(TXD) |=> $stable(TXD) [*4])
		else $error("line level shorter than a bit");
	irq_pulse_a: assert property (TX_IRQ |=> !TX_IRQ)
		else $error("interrupt wider than one cycle");
	wr_answer_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
		|-> ##[1:2] S_AXI_BVALID) else $error("write response missing");
	wr_close_a: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID && S_AXI_AWREADY && S_AXI_WREADY)
		else $error("write not closed");
	wr_refuse_a: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
		else $error("write taken while busy");
	rd_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY)
		else $error("read response missing");
	rd_close_a: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID && S_AXI_ARREADY)
		else $error("read not closed");
endmodule : utc_uart_tx_chk
bind utc_uart_tx utc_uart_tx_chk u_chk (
	.SYS_CLK(SYS_CLK), .SRST(SRST),
	.S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
	.S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
	.S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID),
	.S_AXI_RREADY(S_AXI_RREADY), .TXD(TXD), .TXD_OE(TXD_OE), .TX_IRQ(TX_IRQ)
);
`default_nettype wire

// File: sim/utc_uart_tx_tb_top.sv
// self-checking bench of the transmit channel
`timescale 1ns/100ps
`default_nettype none
module utc_uart_tx_tb_top import utc_pkg::*; ;
	logic SYS_CLK = 1'b0;
	logic SRST = 1'b1;
	logic [ADDR_W-1:0] S_AXI_AWADDR = 5'h00, S_AXI_ARADDR = 5'h00;
	logic [31:0] S_AXI_WDATA = 32'h0;
	logic [3:0] S_AXI_WSTRB = 4'h0;
	logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0, S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
	logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, TXD, TXD_OE, TX_IRQ;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
	logic [31:0] S_AXI_RDATA;
	logic [7:0] rx_byte;
	logic rx_done;
	logic [7:0] rxq[$];
	int err_total = 0, comparisons = 0, irqs = 0;
	wire logic line;
	// released line floats to mark through a pull-up
	assign line = (TXD_OE === 1'b1) ? TXD : 1'b1;
	utc_uart_tx DUT (
		.SYS_CLK(SYS_CLK), .SRST(SRST),
		.S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
		.S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
		.S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
		.S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
		.S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
		.S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
		.TXD(TXD), .TXD_OE(TXD_OE), .TX_IRQ(TX_IRQ)
	);
	utc_rx_model #(.BIT_CLKS(6)) u_rx (.clk(SYS_CLK), .line(line), .rx_byte(rx_byte), .rx_done(rx_done));
	always #12.5 SYS_CLK = ~SYS_CLK;
	// collect frames and interrupt pulses
	always @(posedge SYS_CLK) begin
		if (rx_done === 1'b1) rxq.push_back(rx_byte);
		if (TX_IRQ === 1'b1) irqs++;
	end
	// ****
	// shared tasks
	// ****
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge SYS_CLK);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= d;
		S_AXI_WSTRB <= s;
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WVALID <= 1'b1;
		S_AXI_BREADY <= 1'b1;
		do begin
			@(posedge SYS_CLK);
			if (S_AXI_AWREADY === 1'b1) S_AXI_AWVALID <= 1'b0;
			if (S_AXI_WREADY === 1'b1) S_AXI_WVALID <= 1'b0;
			n++;
		end while (S_AXI_BVALID !== 1'b1 && n < 50);
		S_AXI_BREADY <= 1'b0;
		chk("bvalid", 32'h1, {31'h0, S_AXI_BVALID});
		chk("bresp", {30'h0, (a > OFS_PRES) ? RESP_SLVERR : RESP_OKAY}, {30'h0, S_AXI_BRESP});
	endtask : wr
	task rd(input logic [4:0] a, input logic [31:0] e);
		int n;
		n = 0;
		@(posedge SYS_CLK);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'b1;
		S_AXI_RREADY <= 1'b1;
		do begin
			@(posedge SYS_CLK);
			if (S_AXI_ARREADY === 1'b1) S_AXI_ARVALID <= 1'b0;
			n++;
		end while (S_AXI_RVALID !== 1'b1 && n < 50);
		S_AXI_RREADY <= 1'b0;
		chk("rdata", e, S_AXI_RDATA);
		chk("rresp", {30'h0, (a > OFS_PRES) ? RESP_SLVERR : RESP_OKAY}, {30'h0, S_AXI_RRESP});
	endtask : rd
	// bounded wait for the partner to collect k frames
	task wait_rx(input int k);
		int n;
		n = 0;
		while (rxq.size() < k && n < 2000) begin
			@(posedge SYS_CLK);
			n++;
		end
		chk("frames", k, rxq.size());
	endtask : wait_rx
	// ****
	// scenarios
	// ****
	task t_send;
		wr(5'h14, 32'h1, 4'hF);
		rd(5'h14, 32'h0);
		rd(OFS_TRIG, 32'h0);
		wr(OFS_CTRL, 32'h73, 4'h3);
		rd(OFS_CTRL, 32'h73);
		wr(OFS_TRIG, 32'h1, 4'h1);
		rd(OFS_STAT, 32'h1);
		wr(OFS_DATA, 32'h4A5, 4'h3);
		wait_rx(1);
		chk("byte", 32'hA5, rxq[0]);
		repeat (10) @(posedge SYS_CLK);
		chk("irq", 32'h1, irqs);
		rd(OFS_STAT, 32'h1);
	endtask : t_send
	task t_cont;
		wr(OFS_CTRL, 32'h7B, 4'h3);
		wr(OFS_DATA, 32'h411, 4'h3);
		wr(OFS_DATA, 32'h422, 4'h3);
		wr(OFS_DATA, 32'h433, 4'h3);
		rd(OFS_STAT, 32'h7);
		wait_rx(2);
		repeat (20) @(posedge SYS_CLK);
		wr(OFS_CTRL, 32'h73, 4'h3);
		wait_rx(3);
		repeat (10) @(posedge SYS_CLK);
		chk("byte", 32'h11, rxq[1]);
		chk("byte", 32'h33, rxq[2]);
		chk("irq", 32'h4, irqs);
	endtask : t_cont
	task t_stop;
		wr(OFS_DATA, 32'h400, 4'h3);
		repeat (20) @(posedge SYS_CLK);
		wr(OFS_TRIG, 32'h2, 4'h1);
		rd(OFS_STAT, 32'h0);
		repeat (60) @(posedge SYS_CLK);
		wr(OFS_CTRL, 32'h71, 4'h3);
		@(negedge SYS_CLK);
		chk("oe", 32'h0, TXD_OE);
		chk("txd", 32'h1, TXD);
		repeat (100) @(posedge SYS_CLK);
		chk("frames", 32'h3, rxq.size());
	endtask : t_stop
	task t_gate;
		wr(OFS_CTRL, 32'h73, 4'h3);
		wr(OFS_TRIG, 32'h1, 4'h1);
		wr(OFS_DATA, 32'h400, 4'h3);
		repeat (20) @(posedge SYS_CLK);
		wr(OFS_CTRL, 32'h60, 4'h3);
		@(negedge SYS_CLK);
		chk("txd", 32'h1, TXD);
		rd(OFS_CTRL, 32'h61);
		rd(OFS_STAT, 32'h0);
		repeat (80) @(posedge SYS_CLK);
		rxq.delete();
		wr(OFS_CTRL, 32'h73, 4'h3);
		wr(OFS_TRIG, 32'h1, 4'h1);
		wr(OFS_DATA, 32'h45A, 4'h3);
		wait_rx(1);
		chk("byte", 32'h5A, rxq[0]);
	endtask : t_gate
	// msb first, 7 bits, even parity, two stops, inverted level, slower bit clock;
	// output disabled so the line is watched at the pin and the partner stays idle
	task t_frame;
		int n0;
		logic [10:0] exp_bits;
		exp_bits = 11'h654;
		repeat (10) @(posedge SYS_CLK);
		wr(OFS_CTRL, 32'h294, 4'h3);
		wr(OFS_PRES, 32'h1, 4'h1);
		rd(OFS_PRES, 32'h1);
		n0 = irqs;
		wr(OFS_DATA, 32'h7B5, 4'h3);
		repeat (8) @(negedge SYS_CLK);
		for (int i = 10; i >= 0; i--) begin
			chk("bit", {31'h0, exp_bits[i]}, {31'h0, TXD});
			if (i == 0) chk("irq", n0, irqs);
			repeat (16) @(negedge SYS_CLK);
		end
		chk("irq", n0 + 1, irqs);
		rd(OFS_DATA, 32'h7B5);
	endtask : t_frame
	task print_verdict;
		if (err_total == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : print_verdict
	// main sequence after a six-cycle reset
	initial begin
		repeat (6) @(posedge SYS_CLK);
		SRST <= 1'b0;
		t_send;
		t_cont;
		t_stop;
		t_gate;
		t_frame;
		print_verdict;
	end
	// watchdog, far beyond the roughly one thousand cycles needed
	initial begin
		repeat (20000) @(posedge SYS_CLK);
		err_total++;
		print_verdict;
	end
endmodule : utc_uart_tx_tb_top
`default_nettype wire
